// >>> design/lsu_regs.vh
/*
 * Constants for the load/store memory access path: access size codes,
 * address segment decode, attribute codes and request operation codes.
 * Assumes a 64-bit memory element and a 32-bit virtual address space.
 */
`ifndef LSU_REGS_VH
`define LSU_REGS_VH
`define SIZE_BYTE 3'h0
`define SIZE_HALF 3'h1
`define SIZE_WORD 3'h3
`define SIZE_DOUBLE 3'h7
`define OP_NONE 3'h0
`define OP_LOAD 3'h1
`define OP_STORE 3'h2
`define OP_PREFETCH 3'h3
`define OP_BARRIER 3'h4
`define OP_COP_OPER 3'h5
`define SEG_UNMAPPED_CACHED 3'h4
`define SEG_UNMAPPED_UNCACHED 3'h5
`define ATTR_UNCACHED 3'h2
`define ATTR_CACHED 3'h3
`define UNMAPPED_ADDR_MASK 32'h1fff_ffff
`endif

// >>> design/lane_select.v
/*
 * Byte lane select for one access inside a 64-bit memory element.
 * Assumes the access does not cross the element boundary.
 */
`timescale 1ns/1ns
`include "lsu_regs.vh"
module lane_select (
  input wire [2:0] size_code, // Bytes minus one
  input wire [2:0] addr_low, // Low address bits
  input wire big_endian, // Byte ordering
  output wire [7:0] lanes // Selected lanes
);
  wire [3:0] count;
  wire [2:0] base;
  assign count = {1'b0, size_code} + 4'h1;
  assign base = big_endian ? (3'h7 - addr_low - size_code) : addr_low;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_lane
      assign lanes[i] = (i >= base) && (i < ({1'b0, base} + count));
    end
  endgenerate
endmodule // lane_select

// >>> design/addr_translate.v
/*
 * Virtual to physical address translation with a small mapping table.
 * Assumes the mapping table is loaded through the load port by system code.
 */
`timescale 1ns/1ns
`include "lsu_regs.vh"
module addr_translate #(
  parameter ENTRIES = 4
) (
  input wire clock, // System clock
  input wire reset_n, // Async reset, active low
  input wire [31:0] virtual_addr, // Address to translate
  input wire fetch_or_data_select, // 1 for instruction fetch
  input wire load_or_store_select, // 1 for store
  input wire map_wr, // Load one table entry
  input wire [1:0] map_index, // Entry to load
  input wire [19:0] map_vpage, // Virtual page
  input wire [19:0] map_ppage, // Physical page
  input wire [2:0] map_attr, // Attribute of page
  input wire map_writable, // Page accepts stores
  output reg [31:0] phys_addr, // Translated address
  output reg [2:0] cache_coherency_attribute, // Attribute
  output reg fault // Miss or denied
);
  reg [19:0] vpage_q [0:ENTRIES-1];
  reg [19:0] ppage_q [0:ENTRIES-1];
  reg [2:0] attr_q [0:ENTRIES-1];
  reg [ENTRIES-1:0] valid_q;
  reg [ENTRIES-1:0] wr_ok_q;
  integer k;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      valid_q <= {ENTRIES{1'b0}};
      wr_ok_q <= {ENTRIES{1'b0}};
    end else if (map_wr) begin
      vpage_q[map_index] <= map_vpage;
      ppage_q[map_index] <= map_ppage;
      attr_q[map_index] <= map_attr;
      valid_q[map_index] <= 1'b1;
      wr_ok_q[map_index] <= map_writable;
    end
  end
  always @* begin
    phys_addr = virtual_addr;
    cache_coherency_attribute = `ATTR_UNCACHED;
    fault = 1'b0;
    if (virtual_addr[31:29] == `SEG_UNMAPPED_CACHED ||
        virtual_addr[31:29] == `SEG_UNMAPPED_UNCACHED) begin
      phys_addr = virtual_addr & `UNMAPPED_ADDR_MASK;
      cache_coherency_attribute = virtual_addr[29] ? `ATTR_UNCACHED
                                                   : `ATTR_CACHED;
    end else begin
      fault = 1'b1;
      for (k = 0; k < ENTRIES; k = k + 1) begin
        if (valid_q[k] && vpage_q[k] == virtual_addr[31:12]) begin
          phys_addr = {ppage_q[k], virtual_addr[11:0]};
          cache_coherency_attribute = attr_q[k];
          // Instruction fetches never store, so only data stores check.
          fault = load_or_store_select && !fetch_or_data_select &&
                  !wr_ok_q[k];
        end
      end
    end
  end
endmodule // addr_translate

// >>> design/load_store_unit.v
/*
 * Load/store access path: translation, byte lanes, cached and uncached
 * loads, partial stores, prefetch as a no-op without memory request, barrier and coprocessor exchange.
 * Assumes memory answers one request at a time with mem_ack, and that
 * a cached miss refill of refill_beats elements is done by memory.
 */
`timescale 1ns/1ns
`include "lsu_regs.vh"
module load_store_unit #(
  parameter REFILL_BEATS = 4
) (
  input wire clock, // 20 MHz system clock
  input wire reset_n, // Async reset, active low
  input wire req_valid, // Pipeline request strobe
  input wire [2:0] req_op, // Operation code
  input wire [31:0] virtual_addr, // Virtual address
  input wire fetch_or_data_select, // 1 for instruction fetch
  input wire [2:0] access_size_code, // Bytes minus one
  input wire big_endian, // Byte ordering
  input wire [63:0] store_data, // Store element from pipeline
  input wire cop_sel, // Data goes to or from coprocessor
  input wire cop_double, // Coprocessor doubleword transfer
  input wire [1:0] cop_unit, // Coprocessor unit number
  input wire [4:0] cop_reg, // Coprocessor register
  input wire [24:0] cop_function, // Operation function field
  input wire [4:0] barrier_type, // Ordering type
  input wire map_wr, // Table load strobe
  input wire [1:0] map_index, // Table entry
  input wire [19:0] map_vpage, // Virtual page
  input wire [19:0] map_ppage, // Physical page
  input wire [2:0] map_attr, // Attribute
  input wire map_writable, // Store permitted
  input wire cache_hit, // Cache holds the line
  input wire mem_ack, // Memory done
  input wire [63:0] mem_rdata, // Memory read element
  input wire [63:0] cop_store_word, // Data from coprocessor
  output reg busy, // Request in progress
  output reg done, // Request finished pulse
  output reg exception, // Translation fault pulse
  output reg [63:0] aligned_memory_element, // Load result
  output reg [7:0] load_valid_lanes, // Valid lanes of result
  output reg mem_req, // Memory request
  output reg mem_write, // Store request
  output reg mem_refill, // Cached miss block fetch
  output reg mem_barrier, // Ordering request
  output reg [31:0] mem_addr, // Physical element address
  output reg [2:0] mem_attr, // Attribute
  output reg [7:0] mem_strobe, // Byte lanes
  output reg [63:0] mem_wdata, // Store element
  output reg [4:0] mem_barrier_type, // Ordering type
  output reg cop_load_valid, // Coprocessor load pulse
  output reg [1:0] cop_load_unit, // Unit
  output reg [4:0] cop_load_reg, // Register
  output reg [63:0] cop_load_data, // Word or doubleword
  output reg cop_load_double, // Doubleword flag
  output reg cop_oper_valid, // Operation pulse
  output reg [1:0] cop_oper_unit, // Unit
  output reg [24:0] cop_oper_function // Function field
);
  localparam IDLE = 2'h0;
  localparam MEM = 2'h1;
  localparam FINISH = 2'h2;
  wire [31:0] phys_addr;
  wire [2:0] attr;
  wire fault;
  wire [7:0] lanes;
  wire is_store;
  wire [2:0] size_eff;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg op_load_q;
  reg cop_q;
  reg cop_double_q;
  reg [1:0] unit_q;
  reg [4:0] reg_q;
  reg [7:0] lanes_q;
  reg [2:0] base_q;
  wire [2:0] lane_base;
  wire [63:0] wdata_src;
  wire [63:0] wdata_lanes;
  wire [63:0] rdata_lanes;
  wire [63:0] cop_shift;
  wire [63:0] cop_rdata;

  assign is_store = (req_op == `OP_STORE);
  assign size_eff = !cop_sel ? access_size_code :
                    cop_double ? `SIZE_DOUBLE : `SIZE_WORD;

  // lowest lane of object
  // This mirrors the lane picker, so that a coprocessor word can be moved
  // to and from its lanes; an access that crosses the element is not
  // supported and would lose bytes here.
  assign lane_base = big_endian ?
                     (3'h7 - virtual_addr[2:0] - size_eff) :
                     virtual_addr[2:0];

  // coprocessor word placement
  // A coprocessor hands over its word right-justified, so the word is
  // moved up to the lanes that the address selects.
  assign wdata_src = !cop_sel ? store_data :
                     cop_double ? cop_store_word :
                     ({32'h0000_0000, cop_store_word[31:0]} <<
                      {lane_base, 3'h0});

  assign cop_shift = rdata_lanes >> {base_q, 3'h0};
  assign cop_rdata = cop_double_q ? rdata_lanes :
                     {32'h0000_0000, cop_shift[31:0]};

  // Unreferenced read lanes come back as zero, so that a stale byte from
  // the bus never reaches a register, and unselected store lanes carry
  // zero instead of whatever the pipeline left there.
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_byte
      assign rdata_lanes[8*b+7:8*b] = lanes_q[b] ? mem_rdata[8*b+7:8*b] :
                                                   8'h00;
      assign wdata_lanes[8*b+7:8*b] = lanes[b] ? wdata_src[8*b+7:8*b] :
                                                 8'h00;
    end
  endgenerate

  addr_translate u_xlate (
    .clock(clock),
    .reset_n(reset_n),
    .virtual_addr(virtual_addr),
    .fetch_or_data_select(fetch_or_data_select),
    .load_or_store_select(is_store),
    .map_wr(map_wr),
    .map_index(map_index),
    .map_vpage(map_vpage),
    .map_ppage(map_ppage),
    .map_attr(map_attr),
    .map_writable(map_writable),
    .phys_addr(phys_addr),
    .cache_coherency_attribute(attr),
    .fault(fault)
  );

  lane_select u_lanes (
    .size_code(size_eff),
    .addr_low(virtual_addr[2:0]),
    .big_endian(big_endian),
    .lanes(lanes)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (req_valid) begin
          if (req_op == `OP_LOAD || req_op == `OP_STORE ||
              req_op == `OP_BARRIER) begin
            state_d = (fault && req_op != `OP_BARRIER) ? FINISH : MEM;
          end else if (req_op != `OP_NONE) begin
            state_d = FINISH;
          end
        end
      end
      MEM: begin
        if (mem_ack) begin
          state_d = FINISH;
        end
      end
      FINISH: state_d = IDLE;
      default: state_d = IDLE;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      exception <= 1'b0;
      aligned_memory_element <= 64'h0000_0000_0000_0000;
      load_valid_lanes <= 8'h00;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_refill <= 1'b0;
      mem_barrier <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_attr <= 3'h0;
      mem_strobe <= 8'h00;
      mem_wdata <= 64'h0000_0000_0000_0000;
      mem_barrier_type <= 5'h00;
      cop_load_valid <= 1'b0;
      cop_load_unit <= 2'h0;
      cop_load_reg <= 5'h00;
      cop_load_data <= 64'h0000_0000_0000_0000;
      cop_load_double <= 1'b0;
      cop_oper_valid <= 1'b0;
      cop_oper_unit <= 2'h0;
      cop_oper_function <= 25'h000_0000;
      op_load_q <= 1'b0;
      cop_q <= 1'b0;
      cop_double_q <= 1'b0;
      unit_q <= 2'h0;
      reg_q <= 5'h00;
      lanes_q <= 8'h00;
      base_q <= 3'h0;
    end else begin
      state_q <= state_d;
      done <= 1'b0;
      exception <= 1'b0;
      cop_load_valid <= 1'b0;
      cop_oper_valid <= 1'b0;
      busy <= (state_d != IDLE);
      if (state_q == IDLE && req_valid) begin
        op_load_q <= (req_op == `OP_LOAD);
        cop_q <= cop_sel;
        cop_double_q <= cop_double;
        unit_q <= cop_unit;
        reg_q <= cop_reg;
        lanes_q <= lanes;
        base_q <= lane_base;
        case (req_op)
          `OP_LOAD, `OP_STORE: begin
            if (fault) begin
              exception <= 1'b1;
            end else begin
              mem_req <= 1'b1;
              mem_write <= is_store;
              mem_addr <= {phys_addr[31:3], 3'h0};
              mem_attr <= attr;
              mem_refill <= !is_store && attr == `ATTR_CACHED &&
                            !cache_hit;
              mem_strobe <= lanes;
              mem_wdata <= wdata_lanes;
            end
          end
          `OP_BARRIER: begin
            mem_req <= 1'b1;
            mem_barrier <= 1'b1;
            mem_barrier_type <= barrier_type;
            mem_strobe <= 8'h00;
          end
          `OP_COP_OPER: begin
            cop_oper_valid <= 1'b1;
            cop_oper_unit <= cop_unit;
            cop_oper_function <= cop_function;
          end
          default: ;
        endcase
      end
      if (state_q == MEM && mem_ack) begin
        mem_req <= 1'b0;
        mem_write <= 1'b0;
        mem_refill <= 1'b0;
        mem_barrier <= 1'b0;
        if (op_load_q) begin
          aligned_memory_element <= rdata_lanes;
          load_valid_lanes <= lanes_q;
          if (cop_q) begin
            cop_load_valid <= 1'b1;
            cop_load_unit <= unit_q;
            cop_load_reg <= reg_q;
            cop_load_double <= cop_double_q;
            cop_load_data <= cop_rdata;
          end
        end
      end
      if (state_q == FINISH) begin
        done <= 1'b1;
      end
    end
  end
endmodule // load_store_unit

// >>> verification/mem_side_model.sv
/* Memory and coprocessor model on the far side of the access path.
   Assumes one request at a time, held until mem_ack. */
`timescale 1ns/1ns
module mem_side_model (
  input wire clock, // System clock
  input wire reset_n, // Async reset, active low
  input wire mem_req, // Request level
  input wire mem_write, // Store request
  input wire [31:0] mem_addr, // Element address
  input wire [7:0] mem_strobe, // Byte lanes
  input wire [63:0] mem_wdata, // Store element
  input wire [3:0] lat, // Answer delay in cycles
  input wire [4:0] cop_reg, // Coprocessor register
  output reg mem_ack, // Answer pulse
  output reg [63:0] mem_rdata, // Read element
  output wire [63:0] cop_store_word // Coprocessor data
);
  reg [63:0] mem [0:15];
  reg [3:0] wait_q;
  integer i;
  initial for (i = 0; i < 16; i++) mem[i] = 64'h0;
  // Each half of the register differs, so a wrong half shows.
  assign cop_store_word = {24'h00_0000, 3'h6, cop_reg,
                           24'h00_0000, 3'h5, cop_reg};
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= 64'h0;
    end else if (mem_req && !mem_ack && wait_q < lat) begin
      wait_q <= wait_q + 4'h1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      wait_q <= 4'h0;
      mem_rdata <= mem[mem_addr[6:3]];
      for (i = 0; i < 8; i++)
        if (mem_write && mem_strobe[i])
          mem[mem_addr[6:3]][i*8+:8] <= mem_wdata[i*8+:8];
    end else begin
      // Data no longer held once the answer is over.
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mem_side_model

// >>> verification/lsu_chk.sv
/* Port checker for the load/store unit.
   Assumes the bind below places it on every instance. */
`timescale 1ns/1ns
`include "lsu_regs.vh"
module lsu_chk #(
  parameter REFILL_BEATS = 4
) (
  input wire clock, // System clock
  input wire reset_n, // Async reset
  input wire busy, // In progress
  input wire done, // Finished pulse
  input wire exception, // Fault pulse
  input wire mem_req, // Memory request
  input wire mem_ack, // Memory answer
  input wire mem_write, // Store
  input wire mem_refill, // Block fetch
  input wire mem_barrier, // Ordering request
  input wire [31:0] mem_addr, // Element address
  input wire [2:0] mem_attr, // Attribute
  input wire [7:0] mem_strobe, // Byte lanes
  input wire cop_oper_valid, // Operation pulse
  input wire cop_load_valid // Coprocessor load pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_FAULT_NO_MEM: assert property (exception |-> !mem_req ##1 done)
    else $error("fault did not end without memory request");
  AST_ELEM_ALIGNED: assert property (mem_req |-> mem_addr[2:0] == 3'h0)
    else $error("memory address not element aligned");
  AST_REQ_HELD: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_strobe))
    else $error("request changed before answer");
  AST_ACK_TO_DONE: assert property (mem_req && mem_ack |=>
    !mem_req && !done ##1 done) else $error("done not two after ack");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_COP_OP_DONE: assert property (cop_oper_valid |=> done)
    else $error("operation not completed");
  AST_REFILL_CACHED: assert property (mem_refill |->
    !mem_write && mem_attr == `ATTR_CACHED) else $error("bad refill");
  AST_BARRIER_LANES: assert property (mem_barrier |->
    mem_strobe == 8'h00 && !mem_write) else $error("barrier with lanes");
  AST_STORE_LANES: assert property (mem_req && mem_write |->
    mem_strobe != 8'h00 && busy) else $error("store without lanes");
  COV_REFILL: cover property (mem_refill && mem_ack);
  COV_FAULT: cover property (exception);
  COV_STORE: cover property (mem_write && mem_ack);
  COV_COP: cover property (cop_load_valid);
endmodule // lsu_chk
bind load_store_unit lsu_chk #(.REFILL_BEATS(REFILL_BEATS)) chk_i (
  .clock, .reset_n, .busy, .done, .exception, .mem_req, .mem_ack,
  .mem_write, .mem_refill, .mem_barrier, .mem_addr, .mem_attr,
  .mem_strobe, .cop_oper_valid, .cop_load_valid);

// >>> verification/load_store_unit_bench.sv
/* Self-checking bench for the load/store unit.
   Assumes the memory model answers every request. */
`timescale 1ns/1ns
`include "lsu_regs.vh"
module load_store_unit_bench;
  typedef struct packed {
    logic [2:0] op; logic [31:0] va; logic [2:0] sz; logic be;
    logic hit; logic [7:0] lanes; logic [2:0] attr; logic [63:0] data;
  } row_t;
  localparam logic [63:0] D = 64'h0000_0000_0400_0201;
  row_t rows [0:7] = '{
    '{`OP_STORE, 32'hA000_0013, 3'h0, 1'b0, 1'b0, 8'h08, 3'h2, 64'h0},
    '{`OP_STORE, 32'hA000_0016, 3'h1, 1'b1, 1'b0, 8'h03, 3'h2, 64'h0},
    '{`OP_LOAD, 32'hA000_0010, 3'h7, 1'b1, 1'b0, 8'hff, 3'h2, D},
    '{`OP_LOAD, 32'h8000_0024, 3'h3, 1'b0, 1'b0, 8'hf0, 3'h3, 64'h0},
    '{`OP_LOAD, 32'h8000_0025, 3'h2, 1'b1, 1'b1, 8'h07, 3'h3, 64'h0},
    '{`OP_LOAD, 32'hA000_0010, 3'h4, 1'b0, 1'b0, 8'h1f, 3'h2, D},
    '{`OP_LOAD, 32'hA000_0011, 3'h5, 1'b0, 1'b0, 8'h7e, 3'h2, D},
    '{`OP_LOAD, 32'hA000_0011, 3'h6, 1'b1, 1'b0, 8'h7f, 3'h2, D}};
  logic clock = 1'b0, reset_n = 1'b0, req_valid = 1'b0, big_endian = 1'b0;
  logic fetch_or_data_select = 1'b0, cop_sel = 1'b0, cop_double = 1'b0;
  logic map_wr = 1'b0, map_writable = 1'b0, cache_hit = 1'b0;
  logic [2:0] req_op = 3'h0, access_size_code = 3'h0, map_attr = 3'h0;
  logic [31:0] virtual_addr = 32'h0;
  logic [63:0] store_data = 64'h0, cap = 64'h0;
  logic [1:0] cop_unit = 2'h0, map_index = 2'h0;
  logic [4:0] cop_reg = 5'h0, barrier_type = 5'h0;
  logic [24:0] cop_function = 25'h0;
  logic [19:0] map_vpage = 20'h0, map_ppage = 20'h0;
  logic [3:0] lat = 4'h1;
  logic mem_ack, busy, done, exception, mem_req, mem_write, mem_refill;
  logic mem_barrier, cop_load_valid, cop_load_double, cop_oper_valid;
  logic exc_seen, mreq_seen;
  logic [2:0] kind_seen = 3'h0;
  logic [63:0] mem_rdata, cop_store_word, aligned_memory_element;
  logic [63:0] mem_wdata, cop_load_data;
  logic [7:0] load_valid_lanes, mem_strobe;
  logic [31:0] mem_addr;
  logic [2:0] mem_attr;
  logic [4:0] mem_barrier_type, cop_load_reg;
  logic [1:0] cop_load_unit, cop_oper_unit;
  logic [24:0] cop_oper_function;
  int err_count = 0, n_compared = 0;
  always #25 clock = ~clock;
  load_store_unit dut (.clock, .reset_n, .req_valid, .req_op,
    .virtual_addr, .fetch_or_data_select, .access_size_code, .big_endian,
    .store_data, .cop_sel, .cop_double, .cop_unit, .cop_reg, .cop_function,
    .barrier_type, .map_wr, .map_index, .map_vpage, .map_ppage, .map_attr,
    .map_writable, .cache_hit, .mem_ack, .mem_rdata, .cop_store_word, .busy,
    .done, .exception, .aligned_memory_element, .load_valid_lanes, .mem_req,
    .mem_write, .mem_refill, .mem_barrier, .mem_addr, .mem_attr, .mem_strobe,
    .mem_wdata, .mem_barrier_type, .cop_load_valid, .cop_load_unit,
    .cop_load_reg, .cop_load_data, .cop_load_double, .cop_oper_valid,
    .cop_oper_unit, .cop_oper_function);
  mem_side_model partner (.clock, .reset_n, .mem_req, .mem_write, .mem_addr,
    .mem_strobe, .mem_wdata, .lat, .cop_reg, .mem_ack, .mem_rdata,
    .cop_store_word);
  always @(posedge clock) begin
    if (exception) exc_seen <= 1'b1;
    if (mem_req) mreq_seen <= 1'b1;
    if (mem_req) kind_seen <= {mem_write, mem_refill, mem_barrier};
    if (cop_oper_valid) cap <= {cop_oper_unit, cop_oper_function};
    if (cop_load_valid)
      cap <= {cop_load_double, cop_load_unit, cop_load_reg, cop_load_data[31:0]};
  end
  function automatic [63:0] lmask(input [7:0] l);
    for (int i = 0; i < 8; i++) lmask[i*8+:8] = {8{l[i]}};
  endfunction
  task automatic chk(input string what, input [63:0] exp, input [63:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input [2:0] op, input [31:0] va, input [2:0] sz,
      input be);
    int k;
    @(negedge clock);
    exc_seen = 1'b0;
    mreq_seen = 1'b0;
    req_op = op;
    virtual_addr = va;
    access_size_code = sz;
    big_endian = be;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    chk("done", 64'h1, {63'h0, done});
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(2000 * 50);
    err_count++;
    close_out;
  end
  initial begin
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    chk("idle", 64'h0, {busy, mem_req, done});
    store_data = 64'h0807_0605_0403_0201;
    for (int r = 0; r < 8; r++) begin
      cache_hit = rows[r].hit;
      go(rows[r].op, rows[r].va, rows[r].sz, rows[r].be);
      if (!rows[r].hit) begin
        chk("mem_addr", {35'h0, rows[r].va[28:3], 3'h0}, mem_addr);
        chk("mem_strobe", rows[r].lanes, mem_strobe);
        chk("mem_attr", rows[r].attr, mem_attr);
      end
      chk("kind", {rows[r].op == `OP_STORE, rows[r].op == `OP_LOAD &&
        rows[r].attr == `ATTR_CACHED && !rows[r].hit, 1'b0}, kind_seen);
      if (rows[r].op == `OP_LOAD) begin
        chk("lanes", rows[r].lanes, load_valid_lanes);
        chk("data", rows[r].data & lmask(rows[r].lanes),
          aligned_memory_element & lmask(rows[r].lanes));
      end
      $display("row %0d finished", r);
    end
    cache_hit = 1'b0;
    go(`OP_LOAD, 32'h0000_1000, 3'h3, 1'b0);
    chk("unmapped fault", 2'b10, {exc_seen, mreq_seen});
    map_vpage = 20'h0_0001;
    map_ppage = 20'h0_0003;
    map_attr = `ATTR_UNCACHED;
    map_wr = 1'b1;
    @(negedge clock);
    map_wr = 1'b0;
    go(`OP_LOAD, 32'h0000_1008, 3'h3, 1'b0);
    chk("mapped addr", 35'h2_0000_3008, {mem_attr, mem_addr});
    go(`OP_STORE, 32'h0000_1008, 3'h3, 1'b0);
    chk("store denied", 2'b10, {exc_seen, mreq_seen});
    go(`OP_PREFETCH, 32'hA000_0010, 3'h7, 1'b0);
    chk("prefetch", 2'b00, {exc_seen, mreq_seen});
    barrier_type = 5'h15;
    go(`OP_BARRIER, 32'h0, 3'h0, 1'b0);
    chk("barrier type", 5'h15, mem_barrier_type);
    chk("barrier kind", 3'h1, kind_seen);
    cop_unit = 2'h2;
    cop_function = 25'h1ab_cdef;
    go(`OP_COP_OPER, 32'h0, 3'h0, 1'b0);
    chk("cop oper", {2'h2, 25'h1ab_cdef}, cap);
    $display("hand tests one finished");
    cop_sel = 1'b1;
    cop_unit = 2'h1;
    cop_reg = 5'h07;
    go(`OP_LOAD, 32'hA000_0010, 3'h3, 1'b0);
    chk("cop word", {8'h27, 32'h0400_0201}, cap);
    cop_double = 1'b1;
    lat = 4'h5;
    go(`OP_LOAD, 32'hA000_0010, 3'h7, 1'b0);
    chk("cop double", {8'hA7, 32'h0400_0201}, cap);
    cop_reg = 5'h09;
    go(`OP_STORE, 32'hA000_0018, 3'h7, 1'b0);
    chk("cop store", 64'h0000_00C9_0000_00A9, mem_wdata);
    chk("cop lanes", 8'hff, mem_strobe);
    cop_double = 1'b0;
    go(`OP_STORE, 32'hA000_001C, 3'h3, 1'b0);
    chk("cop word lanes", 8'hf0, mem_strobe);
    chk("cop word", 32'h0000_00A9, mem_wdata[63:32]);
    $display("hand tests two finished");
    cop_sel = 1'b0;
    @(negedge clock);
    req_op = `OP_LOAD;
    virtual_addr = 32'hA000_0010;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    @(negedge clock);
    chk("req in flight", 64'h1, {63'h0, mem_req}); // reset in flight
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    chk("held reset", 64'h0, {busy, mem_req, done, load_valid_lanes}); // reset
    reset_n = 1'b1;
    chk("released", 64'h0, {busy, mem_req, exception, mem_strobe}); // reset
    go(`OP_LOAD, 32'h0000_1008, 3'h3, 1'b0);
    chk("table cleared", 2'b10, {exc_seen, mreq_seen});
    $display("reset test finished");
    close_out;
  end
endmodule // load_store_unit_bench
